// >>> acs_map.vh
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// ----------------------------------------
// Register indices and byte addresses (index times four)
// ----------------------------------------
`define ACS_IDX_CAL_CTRL      8'h50
`define ACS_IDX_BG_CTRL       8'h57
`define ACS_IDX_TIMING_CTRL   8'h66
`define ACS_IDX_STATUS        8'h70
`define ACS_IDX_OFFSET_ADJ    8'h71
`define ACS_ADDR_CAL_CTRL     10'h140
`define ACS_ADDR_BG_CTRL      10'h15C
`define ACS_ADDR_TIMING_CTRL  10'h198
`define ACS_ADDR_STATUS       10'h1C0
`define ACS_ADDR_OFFSET_ADJ   10'h1C4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACS_BIT_CAL_START     3
`define ACS_BIT_LOW_SIGNAL    4
`define ACS_BIT_BG_SELECT     0
`define ACS_BIT_CONT_SELECT   1
`define ACS_BIT_TIMING_EN     0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACS_RST_CAL_CTRL      8'h00
`define ACS_RST_BG_CTRL       8'h00
`define ACS_RST_TIMING_CTRL   8'h00
`define ACS_RST_OFFSET_ADJ    8'h00
`define ACS_STATIC_CODE       16'h0000
// ----------------------------------------
// Calibration durations in sample-clock cycles, and core numbers
// ----------------------------------------
`define ACS_FG_BASE           32'd102000000
`define ACS_FG_LOW            32'd64000000
`define ACS_FG_TIM            32'd227000000
`define ACS_FG_TIM_LOW        32'd189000000
`define ACS_BGI_BASE          32'd127500000
`define ACS_BGI_LOW           32'd80000000
`define ACS_BGI_TIM           32'd283750000
`define ACS_BGI_TIM_LOW       32'd236250000
`define ACS_BG_CYCLE          32'd816000000
`define ACS_BG_CYCLE_LOW      32'd512000000
`define ACS_NUM_CORES         3'd5
`define ACS_LAST_CORE         3'd4
`endif

// >>> acs_sequencer.v
`default_nettype none
`include "acs_map.vh"
// How it works
// RQ1: foreground cal holds output at static code
// RQ2: start bit write launches cal, self clears
// RQ3: cal ends within bounded count, longer timed
// RQ4: plain foreground durations 102M, 227M, 64M
// RQ5: background initial durations 127.5M, 283.75M, 80M
// RQ6: full background rotation 816M or 512M
// RQ7: start resets calibration control logic
// RQ8: software toggles serial link enable afterwards
// RQ9: background powers five cores, one offline
// RQ10: swap offline core online as another leaves
// RQ11: rotation rate fixed, no user setting
// RQ12: software sets both background selects
// RQ13: software triggers start once after setup
// RQ14: offset adjust ignored in background mode
// RQ15: timing enable defaults off, adds timing pass
// RQ16: start bit reads one until cal done
module acs_sequencer #(
    parameter [31:0] FG_BASE      = `ACS_FG_BASE,
    parameter [31:0] FG_LOW       = `ACS_FG_LOW,
    parameter [31:0] FG_TIM       = `ACS_FG_TIM,
    parameter [31:0] FG_TIM_LOW   = `ACS_FG_TIM_LOW,
    parameter [31:0] BGI_BASE     = `ACS_BGI_BASE,
    parameter [31:0] BGI_LOW      = `ACS_BGI_LOW,
    parameter [31:0] BGI_TIM      = `ACS_BGI_TIM,
    parameter [31:0] BGI_TIM_LOW  = `ACS_BGI_TIM_LOW,
    parameter [31:0] BG_CYCLE     = `ACS_BG_CYCLE,
    parameter [31:0] BG_CYCLE_LOW = `ACS_BG_CYCLE_LOW
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [15:0] convCode,
    output reg  [15:0] outCode,
    output reg         calBusy,
    output reg         calCtrlReset,
    output reg         timingCalActive,
    output reg  [4:0]  corePowerOn,
    output reg  [4:0]  coreOnline,
    output reg  [7:0]  offsetAdjOut
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_FG   = 2'd1;
localparam [1:0] ST_BG   = 2'd2;

reg  [1:0]  state_q;
reg  [31:0] count_q;
reg  [31:0] slot_q;
reg  [2:0]  offCore_q;
reg         startBit_q;
reg         lowSig_q;
reg         bgSel_q;
reg         contSel_q;
reg         timEn_q;
reg  [7:0]  offAdj_q;
reg         bgRun_q;

wire        bgMode     = bgSel_q & contSel_q;
wire        wbReq      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire        wbWr       = wbReq & wb_we_i & wb_sel_i[0];
wire        startWr    = wbWr & (wb_adr_i == `ACS_ADDR_CAL_CTRL)
                         & wb_dat_i[`ACS_BIT_CAL_START];
reg  [31:0] fgLen;
reg  [31:0] slotLen;
reg  [7:0]  rdData;

// ----------------------------------------
// Duration selection
// ----------------------------------------
always @* begin
    case ({bgMode, timEn_q, lowSig_q})
        3'b000:  fgLen = FG_BASE;     // see RQ4
        3'b001:  fgLen = FG_LOW;      // see RQ4
        3'b010:  fgLen = FG_TIM;      // see RQ4
        3'b011:  fgLen = FG_TIM_LOW;  // see RQ3
        3'b100:  fgLen = BGI_BASE;    // see RQ5
        3'b101:  fgLen = BGI_LOW;     // see RQ5
        3'b110:  fgLen = BGI_TIM;     // see RQ5
        default: fgLen = BGI_TIM_LOW; // see RQ3
    endcase
    // Per-core slot is one fifth of a full rotation, chosen by lowSig_q only
    slotLen = lowSig_q ? (BG_CYCLE_LOW / 32'd5) : (BG_CYCLE / 32'd5); // see RQ6, RQ11
end

// ----------------------------------------
// Register read mux
// ----------------------------------------
always @* begin
    case (wb_adr_i)
        `ACS_ADDR_CAL_CTRL:    rdData = {3'h0, lowSig_q, startBit_q, 3'h0}; // see RQ16
        `ACS_ADDR_BG_CTRL:     rdData = {6'h00, contSel_q, bgSel_q};
        `ACS_ADDR_TIMING_CTRL: rdData = {7'h00, timEn_q};
        `ACS_ADDR_STATUS:      rdData = {3'h0, offCore_q, bgRun_q, calBusy};
        `ACS_ADDR_OFFSET_ADJ:  rdData = offAdj_q;
        default:               rdData = 8'h00;
    endcase
end

// ----------------------------------------
// Wishbone slave and configuration
// ----------------------------------------
always @(posedge ref_clk) begin
    if (rst) begin
        wb_ack_o  <= 1'b0;
        wb_dat_o  <= 32'h00000000;
        lowSig_q  <= 1'b0;
        bgSel_q   <= 1'b0;
        contSel_q <= 1'b0;
        timEn_q   <= 1'b0; // see RQ15
        offAdj_q  <= `ACS_RST_OFFSET_ADJ;
    end else begin
        wb_ack_o <= wbReq;
        wb_dat_o <= wbReq ? {24'h000000, rdData} : 32'h00000000;
        if (wbWr) begin
            case (wb_adr_i)
                `ACS_ADDR_CAL_CTRL:    lowSig_q <= wb_dat_i[`ACS_BIT_LOW_SIGNAL];
                `ACS_ADDR_BG_CTRL: begin
                    bgSel_q   <= wb_dat_i[`ACS_BIT_BG_SELECT];
                    contSel_q <= wb_dat_i[`ACS_BIT_CONT_SELECT];
                end
                `ACS_ADDR_TIMING_CTRL: timEn_q <= wb_dat_i[`ACS_BIT_TIMING_EN];
                `ACS_ADDR_OFFSET_ADJ:  offAdj_q <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end
end

// ----------------------------------------
// Calibration sequencer
// ----------------------------------------
always @(posedge ref_clk) begin
    if (rst) begin
        state_q         <= ST_IDLE;
        count_q         <= 32'h00000000;
        slot_q          <= 32'h00000000;
        offCore_q       <= 3'h0;
        startBit_q      <= 1'b0;
        bgRun_q         <= 1'b0;
        calBusy         <= 1'b0;
        calCtrlReset    <= 1'b0;
        timingCalActive <= 1'b0;
    end else begin
        calCtrlReset <= startWr; // see RQ7
        if (startWr) begin
            // Restart wipes any running sequence
            state_q         <= ST_FG;               // see RQ2, RQ7
            count_q         <= 32'h00000000;
            slot_q          <= 32'h00000000;
            offCore_q       <= 3'h0;
            startBit_q      <= 1'b1;                // see RQ16
            bgRun_q         <= 1'b0;
            calBusy         <= 1'b1;
            timingCalActive <= timEn_q;             // see RQ15
        end else begin
            case (state_q)
                ST_IDLE: begin
                    calBusy <= 1'b0;
                end
                ST_FG: begin
                    if (count_q + 32'h00000001 >= fgLen) begin // see RQ3
                        startBit_q      <= 1'b0;  // see RQ2, RQ16
                        calBusy         <= 1'b0;
                        timingCalActive <= 1'b0;
                        count_q         <= 32'h00000000;
                        state_q         <= bgMode ? ST_BG : ST_IDLE; // see RQ13
                        bgRun_q         <= bgMode;
                    end else begin
                        count_q <= count_q + 32'h00000001;
                    end
                end
                ST_BG: begin
                    if (!bgMode) begin
                        state_q <= ST_IDLE;
                        bgRun_q <= 1'b0;
                    end else if (slot_q + 32'h00000001 >= slotLen) begin
                        slot_q    <= 32'h00000000;
                        // Calibrated core returns as the next one leaves
                        offCore_q <= (offCore_q == `ACS_LAST_CORE) ? 3'h0
                                     : offCore_q + 3'h1; // see RQ10
                    end else begin
                        slot_q <= slot_q + 32'h00000001;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
end

// ----------------------------------------
// Core control and output data
// ----------------------------------------
always @(posedge ref_clk) begin
    if (rst) begin
        outCode      <= `ACS_STATIC_CODE;
        corePowerOn  <= 5'h0F;
        coreOnline   <= 5'h0F;
        offsetAdjOut <= `ACS_RST_OFFSET_ADJ;
    end else begin
        if (state_q == ST_FG || startWr) begin
            outCode <= `ACS_STATIC_CODE; // see RQ1
        end else begin
            outCode <= convCode;         // see RQ10
        end
        if (bgRun_q) begin
            corePowerOn <= 5'h1F;                        // see RQ9
            coreOnline  <= ~(5'h01 << offCore_q) & 5'h1F; // see RQ9
        end else begin
            corePowerOn <= 5'h0F;
            coreOnline  <= 5'h0F;
        end
        // Stays forced until the rotation has stopped and all cores are back
        offsetAdjOut <= (bgMode | bgRun_q) ? 8'h00 : offAdj_q; // see RQ14
    end
end

endmodule
`default_nettype wire

// >>> acs_sequencer_properties.sv
`default_nettype none
`include "acs_map.vh"
// ----------------------------------------
// Port checks of the calibration sequencer
// ----------------------------------------
module acs_seq_props (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic [15:0] outCode,
    input wire logic        calBusy,
    input wire logic        calCtrlReset,
    input wire logic        timingCalActive,
    input wire logic [4:0]  corePowerOn,
    input wire logic [4:0]  coreOnline,
    input wire logic [7:0]  offsetAdjOut
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic startWr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `ACS_ADDR_CAL_CTRL
                         && wb_dat_i[`ACS_BIT_CAL_START];
    a_ack_answer: assert property (take |=> wb_ack_o)
        else $error("request without ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_start_launch: assert property (startWr |=> calBusy ##[0:1] calCtrlReset)
        else $error("start write did not launch calibration");
    a_reset_pulse: assert property (calCtrlReset |=> !calCtrlReset)
        else $error("control reset pulse too long");
    a_static_out: assert property (calBusy && $past(calBusy) |-> outCode == `ACS_STATIC_CODE)
        else $error("output code moved during calibration");
    a_cal_bounded: assert property ($rose(calBusy) |-> ##[12:46] !calBusy)
        else $error("calibration length out of bounds");
    a_timing_busy: assert property (timingCalActive |-> calBusy)
        else $error("timing pass outside calibration");
    a_core_power: assert property (corePowerOn == 5'h1F ||
        (corePowerOn == 5'h0F && coreOnline == 5'h0F)) else $error("bad core power");
    a_one_offline: assert property (corePowerOn == 5'h1F |->
        $countones(coreOnline) == 4 && offsetAdjOut == 8'h00) else $error("bad offline set");
    a_swap_step: assert property (corePowerOn == 5'h1F && $past(corePowerOn) == 5'h1F
        |-> $countones(coreOnline ^ $past(coreOnline)) inside {0, 2}) else $error("bad swap");
    cover property ($rose(calBusy));
    cover property ($rose(corePowerOn == 5'h1F));
    cover property (timingCalActive);
endmodule
bind acs_sequencer acs_seq_props u_acs_seq_props (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .outCode, .calBusy, .calCtrlReset,
    .timingCalActive, .corePowerOn, .coreOnline, .offsetAdjOut);
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
`include "acs_map.vh"
// ----------------------------------------
// Register level tests of the sequencer
// ----------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DUR [8] = '{20, 12, 40, 30, 25, 15, 45, 35};
    logic        ref_clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [9:0]  wbAdr = 10'h000;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO, rdat;
    logic [15:0] convCode = 16'h1234, outCode, exp16;
    logic        wbAck, calBusy, calCtrlReset, timingCalActive;
    logic [4:0]  corePowerOn, coreOnline;
    logic [7:0]  offsetAdjOut;
    int          fail_count = 0, tests_run = 0, busyLen = 0, lastLen = 0, gap;
    acs_sequencer #(.FG_BASE(20), .FG_LOW(12), .FG_TIM(40), .FG_TIM_LOW(30), .BGI_BASE(25),
        .BGI_LOW(15), .BGI_TIM(45), .BGI_TIM_LOW(35), .BG_CYCLE(50), .BG_CYCLE_LOW(25))
    u_acs_sequencer (.ref_clk, .rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .convCode, .outCode, .calBusy, .calCtrlReset, .timingCalActive,
        .corePowerOn, .coreOnline, .offsetAdjOut);
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        convCode <= convCode + 16'h0101;
        busyLen <= calBusy ? busyLen + 1 : 0;
        if (calBusy) lastLen <= busyLen + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wbXfer(input logic we, input logic [9:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge ref_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, adr, sel, dat};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rdat = wbDatO;
        {wbCyc, wbStb} <= 2'b00;
    endtask
    task automatic rdChk(input logic [9:0] adr, input logic [31:0] exp);
        wbXfer(1'b0, adr, 32'h0, 4'hF);
        check(rdat, exp);
    endtask
    task automatic rotGap(output int g);
        logic [4:0] last;
        last = coreOnline;
        g = 0;
        while (coreOnline === last && g < 200) begin
            @(posedge ref_clk);
            g++;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rdChk(`ACS_ADDR_CAL_CTRL, 32'h0);
        rdChk(`ACS_ADDR_BG_CTRL, 32'h0);
        rdChk(`ACS_ADDR_TIMING_CTRL, 32'h0);
        rdChk(10'h3FC, 32'h0);
        check(corePowerOn, 5'h0F);
        wbXfer(1'b1, `ACS_ADDR_OFFSET_ADJ, 32'h5A, 4'hF);
        wbXfer(1'b1, `ACS_ADDR_OFFSET_ADJ, 32'hFF, 4'hE);
        rdChk(`ACS_ADDR_OFFSET_ADJ, 32'h5A);
        @(posedge ref_clk);
        exp16 = convCode;
        #1 check(outCode, exp16);
        $display("test reset and registers done");
        for (int k = 0; k < 8; k++) begin
            wbXfer(1'b1, `ACS_ADDR_BG_CTRL, {30'h0, k[2], k[2]}, 4'hF);
            wbXfer(1'b1, `ACS_ADDR_TIMING_CTRL, {31'h0, k[1]}, 4'hF);
            wbXfer(1'b1, `ACS_ADDR_CAL_CTRL, {27'h0, k[0], 4'h8}, 4'hF);
            rdChk(`ACS_ADDR_CAL_CTRL, {27'h0, k[0], 4'h8});
            rdChk(`ACS_ADDR_STATUS, 32'h1);
            check(outCode, 32'h0);
            check(timingCalActive, k[1]);
            for (int i = 0; i < 100 && calBusy !== 1'b0; i++) @(posedge ref_clk);
            check(lastLen, DUR[k]);
            rdChk(`ACS_ADDR_CAL_CTRL, {27'h0, k[0], 4'h0});
            check(offsetAdjOut, k[2] ? 8'h00 : 8'h5A);
            check(corePowerOn, k[2] ? 5'h1F : 5'h0F);
            if (k[2]) begin
                rotGap(gap);
                rotGap(gap);
                check(gap, k[0] ? 5 : 10);
            end
            $display("test calibration combination %0d done", k);
        end
        wbXfer(1'b1, `ACS_ADDR_BG_CTRL, 32'h0, 4'hF);
        repeat (3) @(posedge ref_clk);
        check(corePowerOn, 5'h0F);
        $display("test background stop done");
        summarize();
    end
endmodule
`default_nettype wire
